/* logic/mac_pkg.sv */
/*
 * mac_pkg: widths, register offsets, reset values and the control carrier
 * shared by the multiply-accumulate top level and its arithmetic core.
 * assumes a single 200 MHz clock domain and a 32-bit APB register bus.
 */
`default_nettype none

package mac_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // datapath widths
    localparam int MAC_OPND_W = 16;
    localparam int MAC_PROD_W = 35;
    localparam int MAC_RAW_W = 32;
    localparam int MAC_GUARD_W = 3;
    localparam int MAC_UPPER_W = 19;
    localparam int MAC_LOW_LSB = 0;
    localparam int MAC_HIGH_LSB = 16;
    localparam int MAC_GUARD_LSB = 32;

    // one at bit 15, the top of the low word
    localparam logic [34:0] MAC_ROUND_ADD = 35'h0_0000_8000;
    localparam logic [34:0] MAC_PROD_RST = 35'h0_0000_0000;
    localparam logic [15:0] MAC_OPND_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // apb register map
    localparam int MAC_ADDR_W = 12;
    localparam logic [11:0] MAC_OFS_PROD_LOW = 12'h000;
    localparam logic [11:0] MAC_OFS_PROD_EXT = 12'h004;
    localparam logic [11:0] MAC_OFS_CMD = 12'h008;
    localparam int MAC_CMD_CAPTURE_BIT = 0;
    localparam logic [31:0] MAC_RDATA_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // operating controls, captured together
    typedef struct packed {
        logic signed_fmt;
        logic running_total;
        logic subtract;
        logic round;
    } mac_ctl_t;

    localparam mac_ctl_t MAC_CTL_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage

`default_nettype wire

/* logic/mac_core.sv */
/*
 * mac_core: combinational 16x16 multiply, extension to 35 bits, rounding
 * and add/subtract against the current product register.
 * assumes operands and controls are stable register outputs.
 */
`default_nettype none

module mac_core
    import mac_pkg::*;
(
    input wire logic [15:0] x_opnd,
    input wire logic [15:0] y_opnd,
    input wire mac_ctl_t ctl,
    input wire logic [34:0] total_in,
    output logic [34:0] prod_ext,
    output logic [34:0] result
);

    logic signed [31:0] sprod;
    logic [31:0] uprod;
    logic [34:0] rounded;

    assign sprod = $signed(x_opnd) * $signed(y_opnd);
    assign uprod = x_opnd * y_opnd;

    always_comb begin
        // sign fill keeps the guard bits meaningful for negative products
        if (ctl.signed_fmt) begin // RL9
            prod_ext = {{MAC_GUARD_W{sprod[31]}}, sprod}; // RL17
        end else begin
            prod_ext = {3'h0, uprod}; // RL17
        end
        rounded = ctl.round ? prod_ext + MAC_ROUND_ADD : prod_ext; // RL14
        if (!ctl.running_total) begin
            result = rounded; // RL12
        end else if (ctl.subtract) begin
            result = rounded - total_in; // RL13
        end else begin
            result = rounded + total_in; // RL11
        end
    end

endmodule

`default_nettype wire

/* logic/mac_top.sv */
/*
 * mac_top: 16x16 multiplier-accumulator with 35-bit product register,
 * three-state product sections, preload path and an apb status port.
 * assumes all pins, including the three operand/product clocks, are
 * synchronous to REF_CLK; their rising edges are found by sampling.
 */
// Summary of operation
// RL1 - a rising multiplicand clock edge captures the 16-bit multiplicand.
// RL2 - multiplicand and multiplier registers have independent clocks; product is edge-stored.
// RL3 - the multiplier input and low product word share one 16-bit bus, bit 0 lsb.
// RL4 - the product register is 35 bits: low word 0-15, high word 16-31, guard 32-34.
// RL5 - a rising product clock edge stores low word, high word and guard bits together.
// RL6 - each product section has an active-low enable; high leaves its pins undriven.
// RL7 - preload high turns off every product driver whatever the enables say.
// RL8 - with preload high, sections whose enable is high load pin data on a product edge.
// RL9 - signed format high treats operands as two's complement, low as unsigned.
// RL10 - the four controls are captured on a multiplicand or multiplier clock edge.
// RL11 - accumulate high, subtract low stores new product plus the current product.
// RL12 - accumulate low stores the new product directly, subtract ignored.
// RL13 - accumulate and subtract high store new product minus the current product.
// RL14 - round high adds one at bit 15, rounding to the upper 19 bits.
// RL15 - the shared pins switch between input and output by preload and enables.
// RL16 - the host must not drive the shared bus while the device drives it.
// RL17 - the 32-bit product is sign-extended when signed and zero-extended otherwise.
`default_nettype none

module mac_top
    import mac_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MULTIPLICAND_CLOCK,
    input wire logic MULTIPLIER_CLOCK,
    input wire logic PRODUCT_CLOCK,
    input wire logic [15:0] MULTIPLICAND_IN,
    input wire logic [15:0] MULTIPLIER_LOWWORD_BUS_IN,
    output logic [15:0] MULTIPLIER_LOWWORD_BUS_OUT,
    output logic MULTIPLIER_LOWWORD_BUS_OE,
    input wire logic [18:0] PRODUCT_UPPER_BUS_IN,
    output logic [18:0] PRODUCT_UPPER_BUS_OUT,
    output logic HIGH_WORD_OE,
    output logic GUARD_OE,
    input wire logic SIGNED_FORMAT_CTL,
    input wire logic RUNNING_TOTAL_CTL,
    input wire logic SUBTRACT_CTL,
    input wire logic ROUND_CTL,
    input wire logic PRELOAD_CTL,
    input wire logic GUARD_OUT_EN_N,
    input wire logic HIGH_WORD_OUT_EN_N,
    input wire logic LOW_WORD_OUT_EN_N
);

    ////////////////////////////////////////////////////////////////////////////
    // edge detection of the pin clocks
    logic x_clk_prev_ff;
    logic y_clk_prev_ff;
    logic p_clk_prev_ff;
    logic x_edge;
    logic y_edge;
    logic p_edge;
    logic soft_capture;
    logic prod_event;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            x_clk_prev_ff <= 1'b0;
            y_clk_prev_ff <= 1'b0;
            p_clk_prev_ff <= 1'b0;
        end else begin
            x_clk_prev_ff <= MULTIPLICAND_CLOCK;
            y_clk_prev_ff <= MULTIPLIER_CLOCK;
            p_clk_prev_ff <= PRODUCT_CLOCK;
        end
    end

    assign x_edge = MULTIPLICAND_CLOCK & ~x_clk_prev_ff;
    assign y_edge = MULTIPLIER_CLOCK & ~y_clk_prev_ff;
    assign p_edge = PRODUCT_CLOCK & ~p_clk_prev_ff;
    // software capture acts exactly like a product clock edge
    assign prod_event = p_edge | soft_capture;

    ////////////////////////////////////////////////////////////////////////////
    // input registers
    logic [15:0] x_ff;
    logic [15:0] y_ff;
    mac_ctl_t ctl_ff;
    mac_ctl_t ctl_pins;

    assign ctl_pins = '{SIGNED_FORMAT_CTL, RUNNING_TOTAL_CTL, SUBTRACT_CTL, ROUND_CTL};

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            x_ff <= MAC_OPND_RST;
        end else if (x_edge) begin // RL2
            x_ff <= MULTIPLICAND_IN; // RL1
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            y_ff <= MAC_OPND_RST;
        end else if (y_edge) begin // RL2
            y_ff <= MULTIPLIER_LOWWORD_BUS_IN; // RL3
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctl_ff <= MAC_CTL_RST;
        end else if (x_edge || y_edge) begin
            ctl_ff <= ctl_pins; // RL10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arithmetic and product register
    logic [34:0] prod_ff;
    logic [34:0] prod_ext;
    logic [34:0] mac_result;
    logic [34:0] nxt_prod;

    mac_core u_core (
        .x_opnd(x_ff),
        .y_opnd(y_ff),
        .ctl(ctl_ff),
        .total_in(prod_ff),
        .prod_ext(prod_ext),
        .result(mac_result)
    );

    always_comb begin
        nxt_prod = mac_result;
        if (PRELOAD_CTL) begin
            // sections still enabled keep their value during preload
            nxt_prod = prod_ff;
            if (LOW_WORD_OUT_EN_N) begin
                nxt_prod[15:0] = MULTIPLIER_LOWWORD_BUS_IN; // RL8
            end
            if (HIGH_WORD_OUT_EN_N) begin
                nxt_prod[31:16] = PRODUCT_UPPER_BUS_IN[15:0]; // RL8
            end
            if (GUARD_OUT_EN_N) begin
                nxt_prod[34:32] = PRODUCT_UPPER_BUS_IN[18:16]; // RL8
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            prod_ff <= MAC_PROD_RST;
        end else if (prod_event) begin
            prod_ff <= nxt_prod; // RL4 RL5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers; enables lag the control pins by one clock
    logic nxt_low_oe;

    assign nxt_low_oe = ~PRELOAD_CTL & ~LOW_WORD_OUT_EN_N;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            MULTIPLIER_LOWWORD_BUS_OE <= 1'b0;
            HIGH_WORD_OE <= 1'b0;
            GUARD_OE <= 1'b0;
        end else begin
            MULTIPLIER_LOWWORD_BUS_OE <= nxt_low_oe; // RL6 RL7 RL15 RL16
            HIGH_WORD_OE <= ~PRELOAD_CTL & ~HIGH_WORD_OUT_EN_N; // RL6 RL7
            GUARD_OE <= ~PRELOAD_CTL & ~GUARD_OUT_EN_N; // RL6 RL7
        end
    end

    assign MULTIPLIER_LOWWORD_BUS_OUT = prod_ff[15:0];
    assign PRODUCT_UPPER_BUS_OUT = prod_ff[34:16];

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: ready comes in the first cycle of the access phase, no wait states
    logic setup_phase;
    logic wr_done;
    logic [31:0] nxt_rdata;
    logic nxt_err;

    assign setup_phase = PSEL & ~PENABLE;
    assign wr_done = PSEL & PENABLE & PREADY & PWRITE;
    assign soft_capture = wr_done & (PADDR == MAC_OFS_CMD) & PWDATA[MAC_CMD_CAPTURE_BIT];

    always_comb begin
        nxt_rdata = MAC_RDATA_RST;
        nxt_err = 1'b0;
        unique case (PADDR)
            MAC_OFS_PROD_LOW: begin
                nxt_rdata = prod_ff[31:0];
                nxt_err = PWRITE;
            end
            MAC_OFS_PROD_EXT: begin
                nxt_rdata = {24'h00_0000, ctl_ff, 1'b0, prod_ff[34:32]};
                nxt_err = PWRITE;
            end
            MAC_OFS_CMD: begin
                nxt_rdata = MAC_RDATA_RST;
            end
            default: begin
                nxt_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= setup_phase;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA <= MAC_RDATA_RST;
            PSLVERR <= 1'b0;
        end else if (setup_phase) begin
            PRDATA <= PWRITE ? MAC_RDATA_RST : nxt_rdata;
            PSLVERR <= nxt_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_x_capture;
        @(posedge REF_CLK) disable iff (!RST_B)
        x_edge |=> x_ff == $past(MULTIPLICAND_IN);
    endproperty
    a_x_capture: assert property (p_x_capture) else $error("multiplicand not captured"); // RL1

    property p_clocks_independent;
        @(posedge REF_CLK) disable iff (!RST_B)
        (x_edge && !y_edge) |=> y_ff == $past(y_ff);
    endproperty
    a_clocks_independent: assert property (p_clocks_independent) else $error("y moved on x edge"); // RL2

    property p_y_capture;
        @(posedge REF_CLK) disable iff (!RST_B)
        y_edge |=> y_ff == $past(MULTIPLIER_LOWWORD_BUS_IN);
    endproperty
    a_y_capture: assert property (p_y_capture) else $error("multiplier not captured"); // RL3

    property p_prod_hold;
        @(posedge REF_CLK) disable iff (!RST_B)
        !prod_event |=> $stable(prod_ff);
    endproperty
    a_prod_hold: assert property (p_prod_hold) else $error("product moved without edge"); // RL5

    property p_ctl_capture;
        @(posedge REF_CLK) disable iff (!RST_B)
        (x_edge || y_edge) |=> ctl_ff == $past(ctl_pins);
    endproperty
    a_ctl_capture: assert property (p_ctl_capture) else $error("controls not captured"); // RL10

    property p_low_oe;
        @(posedge REF_CLK) disable iff (!RST_B)
        (!PRELOAD_CTL && !LOW_WORD_OUT_EN_N) ##1 !LOW_WORD_OUT_EN_N |->
            MULTIPLIER_LOWWORD_BUS_OE;
    endproperty
    a_low_oe: assert property (p_low_oe) else $error("low word not driven"); // RL6

    property p_low_off;
        @(posedge REF_CLK) disable iff (!RST_B)
        (PRELOAD_CTL || LOW_WORD_OUT_EN_N) |=> !MULTIPLIER_LOWWORD_BUS_OE;
    endproperty
    a_low_off: assert property (p_low_off) else $error("low word driven while off"); // RL15

    property p_high_oe;
        @(posedge REF_CLK) disable iff (!RST_B)
        (!PRELOAD_CTL && !HIGH_WORD_OUT_EN_N) |=> HIGH_WORD_OE;
    endproperty
    a_high_oe: assert property (p_high_oe) else $error("high word not driven"); // RL6

    property p_preload_off;
        @(posedge REF_CLK) disable iff (!RST_B)
        PRELOAD_CTL |=> !MULTIPLIER_LOWWORD_BUS_OE && !HIGH_WORD_OE && !GUARD_OE;
    endproperty
    a_preload_off: assert property (p_preload_off) else $error("driver on in preload"); // RL7

    property p_preload_load;
        @(posedge REF_CLK) disable iff (!RST_B)
        (prod_event && PRELOAD_CTL && HIGH_WORD_OUT_EN_N && !GUARD_OUT_EN_N) |=>
            prod_ff[31:16] == $past(PRODUCT_UPPER_BUS_IN[15:0])
            && prod_ff[34:32] == $past(prod_ff[34:32]);
    endproperty
    a_preload_load: assert property (p_preload_load) else $error("preload wrong"); // RL8

    property p_add;
        @(posedge REF_CLK) disable iff (!RST_B)
        (prod_event && !PRELOAD_CTL && ctl_ff.running_total && !ctl_ff.subtract
            && !ctl_ff.round) |=> prod_ff == $past(prod_ff) + $past(prod_ext);
    endproperty
    a_add: assert property (p_add) else $error("accumulate sum wrong"); // RL11

    property p_direct;
        @(posedge REF_CLK) disable iff (!RST_B)
        (prod_event && !PRELOAD_CTL && !ctl_ff.running_total && !ctl_ff.round) |=>
            prod_ff == $past(prod_ext);
    endproperty
    a_direct: assert property (p_direct) else $error("direct product wrong"); // RL12

    property p_sub;
        @(posedge REF_CLK) disable iff (!RST_B)
        (prod_event && !PRELOAD_CTL && ctl_ff.running_total && ctl_ff.subtract
            && !ctl_ff.round) |=> prod_ff == $past(prod_ext) - $past(prod_ff);
    endproperty
    a_sub: assert property (p_sub) else $error("subtract result wrong"); // RL13

    property p_round;
        @(posedge REF_CLK) disable iff (!RST_B)
        (prod_event && !PRELOAD_CTL && !ctl_ff.running_total && ctl_ff.round) |=>
            prod_ff == $past(prod_ext) + MAC_ROUND_ADD;
    endproperty
    a_round: assert property (p_round) else $error("rounding wrong"); // RL14

    property p_extend;
        @(posedge REF_CLK) disable iff (!RST_B)
        ctl_ff.signed_fmt ? (prod_ext[34:32] == {3{prod_ext[31]}})
                          : (prod_ext[34:32] == 3'h0);
    endproperty
    a_extend: assert property (p_extend) else $error("extension wrong"); // RL9 RL17

    c_add: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        prod_event && !PRELOAD_CTL && ctl_ff.running_total && !ctl_ff.subtract);
    c_sub: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        prod_event && !PRELOAD_CTL && ctl_ff.running_total && ctl_ff.subtract);
    c_preload: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        prod_event && PRELOAD_CTL && LOW_WORD_OUT_EN_N);
    c_soft: cover property (@(posedge REF_CLK) disable iff (!RST_B) soft_capture);

endmodule

`default_nettype wire

/* test/mac_host_bus.sv */
/* mac_host_bus: host side of the shared product pins, resolving each wire.
   assumes the bench asks for a drive only while it means to drive. */
`default_nettype none
module mac_host_bus
    import mac_pkg::*;
(
    input wire logic clk,
    input wire logic lo_en,
    input wire logic [15:0] lo_val,
    input wire logic up_en,
    input wire logic [18:0] up_val,
    input wire logic [15:0] dev_lo,
    input wire logic dev_lo_oe,
    input wire logic [18:0] dev_up,
    input wire logic dev_hi_oe,
    input wire logic dev_gd_oe,
    output logic [15:0] lo_wire,
    output logic [18:0] up_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [18:0] idle = 19'h2_a5a5;
    logic [18:0] up_oe;
    // floating pins toggle so stale data never passes for a match
    always @(posedge clk) idle <= ~idle;
    assign up_oe = {{3{dev_gd_oe}}, {16{dev_hi_oe}}};
    always_comb begin
        // host backs off while the device drives
        if (dev_lo_oe) lo_wire = dev_lo;
        else if (lo_en) lo_wire = lo_val;
        else lo_wire = idle[15:0];
        for (int i = 0; i < 19; i++) begin
            up_wire[i] = up_oe[i] ? dev_up[i] : (up_en ? up_val[i] : idle[i]);
        end
    end
endmodule
`default_nettype wire

/* test/multiply_accumulate_16x16_tb.sv */
/* multiply_accumulate_16x16_tb: pin and apb scenarios for mac_top.
   assumes mac_host_bus resolves the shared wires. */
`default_nettype none
module multiply_accumulate_16x16_tb
    import mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, lo_oe, hi_oe, gd_oe, xclk = 0, yclk = 0, pclk = 0;
    logic lo_en = 0, up_en = 0, preload = 0;
    logic [15:0] x_in = '0, lo_val = '0, lo_out, lo_wire, last_x, last_y;
    logic [18:0] up_val = '0, up_out, up_wire;
    logic [2:0] en_n = 3'h7; // guard, high, low
    logic [34:0] exp_p = '0;
    mac_ctl_t ctl_in = MAC_CTL_RST, exp_c = MAC_CTL_RST;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    mac_top i_mac_top (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MULTIPLICAND_CLOCK(xclk), .MULTIPLIER_CLOCK(yclk),
        .PRODUCT_CLOCK(pclk), .MULTIPLICAND_IN(x_in), .MULTIPLIER_LOWWORD_BUS_IN(lo_wire),
        .MULTIPLIER_LOWWORD_BUS_OUT(lo_out), .MULTIPLIER_LOWWORD_BUS_OE(lo_oe),
        .PRODUCT_UPPER_BUS_IN(up_wire), .PRODUCT_UPPER_BUS_OUT(up_out), .HIGH_WORD_OE(hi_oe),
        .GUARD_OE(gd_oe), .SIGNED_FORMAT_CTL(ctl_in.signed_fmt),
        .RUNNING_TOTAL_CTL(ctl_in.running_total), .SUBTRACT_CTL(ctl_in.subtract),
        .ROUND_CTL(ctl_in.round), .PRELOAD_CTL(preload), .GUARD_OUT_EN_N(en_n[2]),
        .HIGH_WORD_OUT_EN_N(en_n[1]), .LOW_WORD_OUT_EN_N(en_n[0]));
    mac_host_bus i_mac_host_bus (.clk(ref_clk), .lo_en(lo_en), .lo_val(lo_val),
        .up_en(up_en), .up_val(up_val), .dev_lo(lo_out), .dev_lo_oe(lo_oe),
        .dev_up(up_out), .dev_hi_oe(hi_oe), .dev_gd_oe(gd_oe), .lo_wire(lo_wire),
        .up_wire(up_wire));
    ////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        // whole run needs well under a thousand cycles
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    task chk_v(input string what, input logic [34:0] e, input logic [34:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task chk_b(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask
    function automatic logic [34:0] ref_mac(input logic [15:0] x, input logic [15:0] y,
        input mac_ctl_t c, input logic [34:0] cur);
        logic [31:0] p;
        logic [34:0] e;
        if (c.signed_fmt) p = {{16{x[15]}}, x} * {{16{y[15]}}, y};
        else p = {16'h0, x} * {16'h0, y};
        e = c.signed_fmt ? {{3{p[31]}}, p} : {3'h0, p};
        if (c.round) e = e + 35'h8000;
        return !c.running_total ? e : (c.subtract ? e - cur : e + cur);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task pulse(input int k);
        @(posedge ref_clk);
        xclk <= (k == 0);
        yclk <= (k == 1);
        pclk <= (k == 2);
        @(posedge ref_clk);
        {xclk, yclk, pclk} <= 3'h0;
    endtask
    task show;
        @(posedge ref_clk);
        en_n <= 3'h0;
        repeat (3) @(posedge ref_clk);
        chk_v("product pins", exp_p, {up_wire, lo_wire});
        en_n <= 3'h7;
        repeat (3) @(posedge ref_clk);
    endtask
    // the first operand edge sees inverted controls, so only the later edge can win
    task mac_op(input logic [15:0] x, input logic [15:0] y, input mac_ctl_t c,
        input logic on_y);
        @(posedge ref_clk);
        x_in <= x;
        lo_val <= y;
        lo_en <= 1'b1;
        ctl_in <= ~c;
        pulse(on_y ? 0 : 1);
        ctl_in <= c;
        pulse(on_y ? 1 : 0);
        ctl_in <= ~c;
        lo_en <= 1'b0;
        x_in <= ~x;
        pulse(2);
        last_x = x;
        last_y = y;
        exp_c = c;
        exp_p = ref_mac(x, y, c, exp_p);
        show();
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // no wait limit here: a slave that never answers ends at the bench timeout
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task apb_checks;
        logic [31:0] rd;
        logic err;
        apb(1'b0, MAC_OFS_PROD_LOW, 32'h0, rd, err);
        chk_v("prod low", {3'h0, exp_p[31:0]}, {3'h0, rd});
        chk_b("read err", 1'b0, err);
        apb(1'b0, MAC_OFS_CMD, 32'h0, rd, err);
        chk_v("cmd read", 35'h0, {3'h0, rd});
        apb(1'b0, MAC_OFS_PROD_EXT, 32'h0, rd, err);
        chk_v("prod ext", {27'h0, exp_c, 1'b0, exp_p[34:32]}, {3'h0, rd});
        apb(1'b1, MAC_OFS_PROD_LOW, 32'h1234_5678, rd, err);
        chk_b("read-only err", 1'b1, err);
        apb(1'b0, 12'hffc, 32'h0, rd, err);
        chk_b("unmapped err", 1'b1, err);
        chk_v("unmapped data", 35'h0, {3'h0, rd});
        apb(1'b1, MAC_OFS_CMD, 32'h1, rd, err);
        exp_p = ref_mac(last_x, last_y, exp_c, exp_p);
        show();
    endtask
    task oe_table;
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            {preload, en_n} <= 4'(i);
            repeat (3) @(posedge ref_clk);
            chk_b("low oe", !preload && !en_n[0], lo_oe);
            chk_b("high oe", !preload && !en_n[1], hi_oe);
            chk_b("guard oe", !preload && !en_n[2], gd_oe);
        end
        preload <= 1'b0;
        en_n <= 3'h7;
    endtask
    task preload_sec(input logic [2:0] en, input logic [18:0] u, input logic [15:0] l);
        @(posedge ref_clk);
        preload <= 1'b1;
        en_n <= en;
        up_val <= u;
        lo_val <= l;
        up_en <= 1'b1;
        lo_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        pulse(2);
        {up_en, lo_en, preload} <= 3'h0;
        en_n <= 3'h7;
        if (en[0]) exp_p[15:0] = l;
        if (en[1]) exp_p[31:16] = u[15:0];
        if (en[2]) exp_p[34:32] = u[18:16];
        show();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        show();
        mac_op(16'hffff, 16'hffff, mac_ctl_t'(4'h0), 1'b1);
        mac_op(16'hffff, 16'h0002, mac_ctl_t'(4'h8), 1'b0);
        mac_op(16'h0003, 16'h0004, mac_ctl_t'(4'hc), 1'b1);
        mac_op(16'h0005, 16'h0007, mac_ctl_t'(4'he), 1'b0);
        apb_checks();
        mac_op(16'h0001, 16'h0001, mac_ctl_t'(4'h3), 1'b1);
        oe_table();
        preload_sec(3'h7, 19'h5_1234, 16'habcd);
        preload_sec(3'h2, 19'h2_9876, 16'h1111);
        preload_sec(3'h5, 19'h3_0f0f, 16'h2222);
        mac_op(16'h8000, 16'h8000, mac_ctl_t'(4'hd), 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
